// file: hdl/erdis_top.sv
// Event router: DMA channel event latches and CPU interrupt selector
//
// Operation
// RQ1: Sixty-four DMA channels, each with at most one fixed, unprogrammable event source.
// RQ2: Events latch into the latch registers even when their enable bit is clear.
// RQ3: Channel service priority comes from its parameter RAM entry.
// RQ4: Channels 0-3: host interrupt, timer 0, timer 1, memory A refresh.
// RQ5: Pin events 4-7 to channels 4-7, 0-3 to 8-11, 8-15 to 48-55.
// RQ6: Serial ports to 12-15 and 17-18, timer 2 to 19, memory B to 20.
// RQ7: Viterbi receive/transmit to 28/29, turbo receive/transmit to 30/31.
// RQ8: Cell receive event to channel 32, cell transmit event to 40.
// RQ9: Channels 16, 21-27, 33-39, 41-47, 56-63 have no source.
// RQ10: Every channel is also triggered by completion chaining events.
// RQ11: Events of an absent peripheral are treated reserved, never asserted.
// RQ12: Sixteen CPU interrupts, 0 highest priority, 15 lowest.
// RQ13: Interrupts 0-3 are fixed and non-maskable, no selector.
// RQ14: Interrupts 4-15 take programmable sources, with reset defaults.
// RQ15: Selector registers at 0x019C0000 (high) and 0x019C0004 (low).
// RQ16: Five-bit fields at [4:0],[9:5],[14:10],[20:16],[25:21],[30:26].
// RQ17: Reset codes 4-9, 3, 10, 11, 0, 1, 2 for interrupts 4-15.
// RQ18: Latch holds until cleared or serviced; request needs latch and enable.
// RQ19: Each code picks one event line; reserved codes give no interrupt.
`timescale 1ns/1ps
`default_nettype none
`include "erdis_defs.svh"

module erdis_top
  import erdis_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        SRST,
  // Register port
  input  wire logic [31:0] REG_ADDR,
  input  wire logic [31:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [31:0] REG_RDATA,
  // Peripheral events and CPU sources
  input  wire erdis_evt_t  PERIPH_EVT,
  input  wire erdis_isrc_t CPU_SRC,
  // DMA channel side
  input  wire logic [63:0] CHAIN_EVT,
  input  wire logic [63:0] CHAN_SERVICED,
  input  wire logic [63:0] PARAM_HI_PRIO,
  output logic      [63:0] CHAN_REQ_HI,
  output logic      [63:0] CHAN_REQ_LO,
  // CPU side
  output logic      [15:0] CPU_INT,
  output logic             CPU_INT_ANY,
  output logic      [3:0]  CPU_INT_TOP,
  // Block interrupt
  output logic             IRQ
);

  // ==========================================================
  // Functions
  // Pick one line out of 32 by selector code
  // Reserved codes hit tied-low lines
  // Five bits always index inside
  function automatic logic sel_line(
    input logic [`ERDIS_SEL_W-1:0] code,
    input logic [31:0]             src
  );
    sel_line = src[code];
  endfunction : sel_line

  // Lowest set index wins, matching CPU priority order
  // Scans down; last hit is lowest
  // Idle vector reports zero
  // Qualify it with the any flag
  function automatic logic [3:0] top_int(
    input logic [15:0] v
  );
    top_int = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) begin
        top_int = 4'(i);
      end
    end
  endfunction : top_int

  // ==========================================================
  // Registers
  // Channel words stay 64 wide
  // Halves split only at the bus
  // Next values come from assigns, rdata_next from always_comb
  logic [31:0]              hi_sel_reg;
  logic [31:0]              lo_sel_reg;
  logic [63:0]              latch_reg;
  logic [63:0]              latch_next;
  logic [63:0]              mask_reg;
  logic [`ERDIS_STAT_W-1:0] status_reg;
  logic [`ERDIS_STAT_W-1:0] status_next;
  logic [`ERDIS_STAT_W-1:0] imask_reg;
  logic [`ERDIS_CFG_W-1:0]  config_reg;
  logic [31:0]              rdata_next;
  logic [15:0]              cpu_int_next;

  // ==========================================================
  // Address decode
  // Full compare avoids aliasing
  // Unmapped: reads zero, no write
  // One decode for read and write
  wire hit_hi_sel   = REG_ADDR == `ERDIS_ADDR_HI_SEL;
  wire hit_lo_sel   = REG_ADDR == `ERDIS_ADDR_LO_SEL;
  wire hit_latch_lo = REG_ADDR == `ERDIS_ADDR_LATCH_LO;
  wire hit_latch_hi = REG_ADDR == `ERDIS_ADDR_LATCH_HI;
  wire hit_mask_lo  = REG_ADDR == `ERDIS_ADDR_MASK_LO;
  wire hit_mask_hi  = REG_ADDR == `ERDIS_ADDR_MASK_HI;
  wire hit_status   = REG_ADDR == `ERDIS_ADDR_STATUS;
  wire hit_imask    = REG_ADDR == `ERDIS_ADDR_IMASK;
  wire hit_config   = REG_ADDR == `ERDIS_ADDR_CONFIG;

  // ==========================================================
  // Peripheral presence gating
  // Absent blocks may float their lines; gate before latching
  // Bits: host, cell, coprocessors
  // Also keeps interrupt lines clean
  wire host_ok  = config_reg[`ERDIS_CFG_HOST];  // [RQ11]
  wire cell_ok  = config_reg[`ERDIS_CFG_CELL];  // [RQ11]
  wire copro_ok = config_reg[`ERDIS_CFG_COPRO]; // [RQ11]

  // ==========================================================
  // Fixed event-to-channel map, not software visible
  // Map cannot be changed at all
  // Unused channels tie low
  // Only chaining sets those bits
  // Host, cell, coprocessor gated
  // Other blocks always fitted
  wire [63:0] chan_evt;
  assign chan_evt[0]     = PERIPH_EVT.host & host_ok;        // [RQ1] [RQ4]
  assign chan_evt[1]     = PERIPH_EVT.timer[0];              // [RQ4]
  assign chan_evt[2]     = PERIPH_EVT.timer[1];              // [RQ4]
  assign chan_evt[3]     = PERIPH_EVT.mem_refresh[0];        // [RQ4]
  assign chan_evt[7:4]   = PERIPH_EVT.pin[7:4];              // [RQ5]
  assign chan_evt[11:8]  = PERIPH_EVT.pin[3:0];              // [RQ5]
  assign chan_evt[12]    = PERIPH_EVT.serial_tx[0];          // [RQ6]
  assign chan_evt[13]    = PERIPH_EVT.serial_rx[0];          // [RQ6]
  assign chan_evt[14]    = PERIPH_EVT.serial_tx[1];          // [RQ6]
  assign chan_evt[15]    = PERIPH_EVT.serial_rx[1];          // [RQ6]
  assign chan_evt[16]    = 1'b0;                             // [RQ9]
  assign chan_evt[17]    = PERIPH_EVT.serial_tx[2];          // [RQ6]
  assign chan_evt[18]    = PERIPH_EVT.serial_rx[2];          // [RQ6]
  assign chan_evt[19]    = PERIPH_EVT.timer[2];              // [RQ6]
  assign chan_evt[20]    = PERIPH_EVT.mem_refresh[1];        // [RQ6]
  assign chan_evt[27:21] = 7'h00;                            // [RQ9]
  assign chan_evt[28]    = PERIPH_EVT.viterbi_rx & copro_ok; // [RQ7]
  assign chan_evt[29]    = PERIPH_EVT.viterbi_tx & copro_ok; // [RQ7]
  assign chan_evt[30]    = PERIPH_EVT.turbo_rx & copro_ok;   // [RQ7]
  assign chan_evt[31]    = PERIPH_EVT.turbo_tx & copro_ok;   // [RQ7]
  assign chan_evt[32]    = PERIPH_EVT.cell_rx & cell_ok;     // [RQ8]
  assign chan_evt[39:33] = 7'h00;                            // [RQ9]
  assign chan_evt[40]    = PERIPH_EVT.cell_tx & cell_ok;     // [RQ8]
  assign chan_evt[47:41] = 7'h00;                            // [RQ9]
  assign chan_evt[55:48] = PERIPH_EVT.pin[15:8];             // [RQ5]
  assign chan_evt[63:56] = 8'h00;                            // [RQ9]

  // Chaining completions can trigger any channel
  // Any channel may be chained
  // Chain pulses skip the gate
  // They come from the controller
  wire [63:0] chan_trig = chan_evt | CHAIN_EVT; // [RQ10]

  // ==========================================================
  // Event latch next state
  // Software writes one to clear; a new event wins over clear
  // Clear winning would lose an
  // Event in the acknowledge cycle
  // Service clears like software
  wire [63:0] sw_clr = {hit_latch_hi & REG_WR ? REG_WDATA : 32'h0,
                        hit_latch_lo & REG_WR ? REG_WDATA : 32'h0};
  // Enable mask does not gate capture
  assign latch_next = (latch_reg & ~sw_clr & ~CHAN_SERVICED)
                    | chan_trig; // [RQ2] [RQ18]

  // Request only with latch and enable both set
  // Enable never gates capture
  // Masked events wait in latch
  // Request rises once enabled
  wire [63:0] chan_req = latch_reg & mask_reg; // [RQ18]

  // ==========================================================
  // Block status events
  // Bits 0, 1: trigger per half
  // Bit 2: trigger on a set bit
  // Two events share one transfer
  // Sticky, write one to clear
  wire [`ERDIS_STAT_W-1:0] stat_evt;
  assign stat_evt[`ERDIS_STAT_LATCH_LO] = |chan_trig[31:0];
  assign stat_evt[`ERDIS_STAT_LATCH_HI] = |chan_trig[63:32];
  // Event onto an already latched bit is lost service
  assign stat_evt[`ERDIS_STAT_OVERRUN]  = |(chan_trig & latch_reg);

  wire [`ERDIS_STAT_W-1:0] stat_clr =
    hit_status & REG_WR ? REG_WDATA[`ERDIS_STAT_W-1:0] : '0;
  // Set side wins over clear
  assign status_next = (status_reg & ~stat_clr) | stat_evt;

  // ==========================================================
  // CPU interrupt source vector indexed by selector code
  // Vector position is the code
  // Codes 21, 22, 24-29 read low
  // Serial irqs use the CPU bundle
  wire [31:0] isrc;
  assign isrc[0]     = PERIPH_EVT.host & host_ok;
  assign isrc[1]     = PERIPH_EVT.timer[0];
  assign isrc[2]     = PERIPH_EVT.timer[1];
  assign isrc[3]     = PERIPH_EVT.mem_refresh[0];
  assign isrc[7:4]   = PERIPH_EVT.pin[7:4];
  assign isrc[8]     = CPU_SRC.dma_done;
  assign isrc[9]     = CPU_SRC.emu_dtdma;
  assign isrc[10]    = CPU_SRC.emu_rtdx_rx;
  assign isrc[11]    = CPU_SRC.emu_rtdx_tx;
  assign isrc[12]    = CPU_SRC.serial_tx[0];
  assign isrc[13]    = CPU_SRC.serial_rx[0];
  assign isrc[14]    = CPU_SRC.serial_tx[1];
  assign isrc[15]    = CPU_SRC.serial_rx[1];
  assign isrc[16]    = PERIPH_EVT.pin[0];
  assign isrc[17]    = CPU_SRC.serial_tx[2];
  assign isrc[18]    = CPU_SRC.serial_rx[2];
  assign isrc[19]    = PERIPH_EVT.timer[2];
  assign isrc[20]    = PERIPH_EVT.mem_refresh[1];
  assign isrc[22:21] = 2'h0;                           // [RQ19]
  assign isrc[23]    = CPU_SRC.cell_irq & cell_ok;
  assign isrc[29:24] = 6'h00;                          // [RQ19]
  assign isrc[30]    = CPU_SRC.viterbi_irq & copro_ok;
  assign isrc[31]    = CPU_SRC.turbo_irq & copro_ok;

  // ==========================================================
  // Interrupt selection
  // Fixed lines: reset, nmi, two reserved held low
  // No selector: reset and nmi
  // Never move down in priority
  assign cpu_int_next[0] = CPU_SRC.reset_req; // [RQ13]
  assign cpu_int_next[1] = CPU_SRC.nmi;       // [RQ13]
  assign cpu_int_next[3:2] = 2'h0;            // [RQ13]

  // Field k of each selector register; bit 15 is a gap
  // Upper fields start a bit higher
  // Codes feed 4..15 in order
  // Selection flopped at output
  // New code acts a cycle later
  genvar k;
  generate
    for (k = 0; k < 6; k++) begin : g_sel
      localparam int LSB = k * 5 + (k >= 3 ? 1 : 0);
      // Low register feeds 4..9, high feeds 10..15
      assign cpu_int_next[4 + k] =
        sel_line(lo_sel_reg[LSB +: `ERDIS_SEL_W], isrc); // [RQ14] [RQ16] [RQ19]
      assign cpu_int_next[10 + k] =
        sel_line(hi_sel_reg[LSB +: `ERDIS_SEL_W], isrc); // [RQ14] [RQ16] [RQ19]
    end
  endgenerate

  // ==========================================================
  // Read mux; unmapped addresses return zero
  // Output flop gates by strobe
  // Bus sees zero between answers
  always_comb begin
    rdata_next = 32'h0;
    if (hit_hi_sel) begin
      rdata_next = hi_sel_reg;
    end else if (hit_lo_sel) begin
      rdata_next = lo_sel_reg;
    end else if (hit_latch_lo) begin
      rdata_next = latch_reg[31:0];
    end else if (hit_latch_hi) begin
      rdata_next = latch_reg[63:32];
    end else if (hit_mask_lo) begin
      rdata_next = mask_reg[31:0];
    end else if (hit_mask_hi) begin
      rdata_next = mask_reg[63:32];
    end else if (hit_status) begin
      rdata_next = {29'h0, status_reg};
    end else if (hit_imask) begin
      rdata_next = {29'h0, imask_reg};
    end else if (hit_config) begin
      rdata_next = {29'h0, config_reg};
    end
  end

  // ==========================================================
  // Selector registers, reserved bits stay zero
  // Write mask keeps bits 15, 31 low
  // Readback matches what selects
  always_ff @(posedge CLK) begin
    if (SRST) begin
      hi_sel_reg <= `ERDIS_HI_SEL_RST; // [RQ17]
      lo_sel_reg <= `ERDIS_LO_SEL_RST; // [RQ17]
    end else begin
      if (REG_WR && hit_hi_sel) begin
        hi_sel_reg <= REG_WDATA & `ERDIS_SEL_WMASK; // [RQ15]
      end
      if (REG_WR && hit_lo_sel) begin
        lo_sel_reg <= REG_WDATA & `ERDIS_SEL_WMASK; // [RQ15]
      end
    end
  end

  // ==========================================================
  // Event latch and enable mask
  // Latch updates every cycle
  // Service and clear share a path
  // Mask resets to all disabled
  always_ff @(posedge CLK) begin
    if (SRST) begin
      latch_reg <= 64'h0;
      mask_reg  <= 64'h0;
    end else begin
      latch_reg <= latch_next;
      if (REG_WR && hit_mask_lo) begin
        mask_reg[31:0] <= REG_WDATA;
      end
      if (REG_WR && hit_mask_hi) begin
        mask_reg[63:32] <= REG_WDATA;
      end
    end
  end

  // ==========================================================
  // Status, interrupt mask and presence config
  // Presence resets to all fitted
  // Clear bits of absent blocks
  always_ff @(posedge CLK) begin
    if (SRST) begin
      status_reg <= '0;
      imask_reg  <= '0;
      config_reg <= `ERDIS_CFG_RST;
    end else begin
      status_reg <= status_next;
      if (REG_WR && hit_imask) begin
        imask_reg <= REG_WDATA[`ERDIS_STAT_W-1:0];
      end
      if (REG_WR && hit_config) begin
        config_reg <= REG_WDATA[`ERDIS_CFG_W-1:0];
      end
    end
  end

  // ==========================================================
  // Output flops
  // Requests split by per-channel priority from parameter RAM
  // All outputs come from flops
  // One cycle late, never glitching
  // Priority sampled with request
  // RAM changes lag one cycle
  // IRQ uses next status, so an
  // Event raises IRQ on that edge
  // Read data zero except answers
  always_ff @(posedge CLK) begin
    if (SRST) begin
      REG_RDATA   <= 32'h0;
      CHAN_REQ_HI <= 64'h0;
      CHAN_REQ_LO <= 64'h0;
      CPU_INT     <= 16'h0;
      CPU_INT_ANY <= 1'b0;
      CPU_INT_TOP <= 4'h0;
      IRQ         <= 1'b0;
    end else begin
      REG_RDATA   <= REG_RD ? rdata_next : 32'h0;
      CHAN_REQ_HI <= chan_req & PARAM_HI_PRIO;  // [RQ3]
      CHAN_REQ_LO <= chan_req & ~PARAM_HI_PRIO; // [RQ3]
      CPU_INT     <= cpu_int_next;
      CPU_INT_ANY <= |cpu_int_next;
      CPU_INT_TOP <= top_int(cpu_int_next); // [RQ12]
      IRQ         <= |(status_next & imask_reg);
    end
  end

endmodule : erdis_top
`default_nettype wire

// file: hdl/erdis_defs.svh
// Register map, field layout, reset values for the event router
`ifndef ERDIS_DEFS_SVH
`define ERDIS_DEFS_SVH

// ==========================================================
// Register byte addresses
`define ERDIS_ADDR_HI_SEL   32'h019C0000
`define ERDIS_ADDR_LO_SEL   32'h019C0004
`define ERDIS_ADDR_LATCH_LO 32'h019C0010
`define ERDIS_ADDR_LATCH_HI 32'h019C0014
`define ERDIS_ADDR_MASK_LO  32'h019C0018
`define ERDIS_ADDR_MASK_HI  32'h019C001C
`define ERDIS_ADDR_STATUS   32'h019C0020
`define ERDIS_ADDR_IMASK    32'h019C0024
`define ERDIS_ADDR_CONFIG   32'h019C0028

// ==========================================================
// Selector fields and reset values
`define ERDIS_SEL_W         5
`define ERDIS_SEL_WMASK     32'h7FFF7FFF
`define ERDIS_LO_SEL_RST    32'h250718A4
`define ERDIS_HI_SEL_RST    32'h08202D43

// ==========================================================
// Status / config bit positions and widths
`define ERDIS_STAT_W        3
`define ERDIS_STAT_LATCH_LO 0
`define ERDIS_STAT_LATCH_HI 1
`define ERDIS_STAT_OVERRUN  2
`define ERDIS_CFG_W         3
`define ERDIS_CFG_HOST      0
`define ERDIS_CFG_CELL      1
`define ERDIS_CFG_COPRO     2
`define ERDIS_CFG_RST       3'h7
`define ERDIS_CHANNELS      64
`define ERDIS_NUM_INT       16

`endif

// file: hdl/erdis_pkg.sv
// Types for the event router and interrupt selector
package erdis_pkg;

  // ==========================================================
  // Peripheral synchronization event lines
  typedef struct packed {
    logic        host;
    logic [2:0]  timer;
    logic [1:0]  mem_refresh;
    logic [15:0] pin;
    logic [2:0]  serial_tx;
    logic [2:0]  serial_rx;
    logic        viterbi_rx;
    logic        viterbi_tx;
    logic        turbo_rx;
    logic        turbo_tx;
    logic        cell_rx;
    logic        cell_tx;
  } erdis_evt_t;

  // ==========================================================
  // CPU-only interrupt source lines
  typedef struct packed {
    logic       reset_req;
    logic       nmi;
    logic       dma_done;
    logic       emu_dtdma;
    logic       emu_rtdx_rx;
    logic       emu_rtdx_tx;
    logic [2:0] serial_tx;
    logic [2:0] serial_rx;
    logic       cell_irq;
    logic       viterbi_irq;
    logic       turbo_irq;
  } erdis_isrc_t;

endpackage : erdis_pkg

// file: sim/erdis_monitor.sv
// Port-level checker for the event router
`timescale 1ns/1ps
`default_nettype none
module erdis_monitor
  import erdis_pkg::*;
(
  // Clock, reset and read port
  input wire logic        CLK,
  input wire logic        SRST,
  input wire logic        REG_RD,
  input wire logic [31:0] REG_RDATA,
  // Channel side
  input wire logic [63:0] CHAIN_EVT,
  input wire logic [63:0] CHAN_SERVICED,
  input wire logic [63:0] PARAM_HI_PRIO,
  input wire logic [63:0] CHAN_REQ_HI,
  input wire logic [63:0] CHAN_REQ_LO,
  // CPU side
  input wire erdis_isrc_t CPU_SRC,
  input wire logic [15:0] CPU_INT,
  input wire logic        CPU_INT_ANY,
  input wire logic [3:0]  CPU_INT_TOP
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  // ==========================================================
  // Steps; past values right after reset are not trusted
  sequence no_read_s; !REG_RD; endsequence
  sequence live_s; !$past(SRST); endsequence
  sequence served_s; CHAN_SERVICED[63] && !CHAIN_EVT[63]; endsequence

  // ==========================================================
  // Checks
  rdata_idle_a: assert property (no_read_s |=> REG_RDATA == 32'h0)
    else $error("read data not zero outside a read answer");
  req_split_a: assert property ((CHAN_REQ_HI & CHAN_REQ_LO) == 64'h0)
    else $error("channel request on both priority lines");
  req_hi_prio_a: assert property (live_s |-> (CHAN_REQ_HI & ~$past(PARAM_HI_PRIO)) == 64'h0)
    else $error("high request without high priority");
  req_lo_prio_a: assert property (live_s |-> (CHAN_REQ_LO & $past(PARAM_HI_PRIO)) == 64'h0)
    else $error("low request with high priority");
  int_fixed_a: assert property (CPU_INT[3:2] == 2'h0)
    else $error("reserved fixed interrupt raised");
  int_follow_a: assert property (live_s |-> CPU_INT[0] == $past(CPU_SRC.reset_req)
    && CPU_INT[1] == $past(CPU_SRC.nmi))
    else $error("fixed interrupt does not follow its source");
  int_any_a: assert property (CPU_INT_ANY == (CPU_INT != 16'h0))
    else $error("any flag disagrees with interrupts");
  int_top_a: assert property (CPU_INT != 16'h0 |-> CPU_INT[CPU_INT_TOP]
    && (CPU_INT & ((16'h1 << CPU_INT_TOP) - 16'h1)) == 16'h0)
    else $error("top interrupt is not the lowest index set");
  top_idle_a: assert property (CPU_INT == 16'h0 |-> CPU_INT_TOP == 4'h0)
    else $error("top index not zero while idle");
  svc_clear_a: assert property (served_s |-> ##2 !(CHAN_REQ_HI[63] || CHAN_REQ_LO[63]))
    else $error("serviced channel still requesting");
endmodule : erdis_monitor

bind erdis_top erdis_monitor i_erdis_monitor (.CLK, .SRST, .REG_RD, .REG_RDATA, .CHAIN_EVT,
  .CHAN_SERVICED, .PARAM_HI_PRIO, .CHAN_REQ_HI, .CHAN_REQ_LO, .CPU_SRC, .CPU_INT,
  .CPU_INT_ANY, .CPU_INT_TOP);
`default_nettype wire

// file: sim/erdis_partner.sv
// Channel controller model that consumes pending requests
`timescale 1ns/1ps
`default_nettype none
module erdis_partner (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // Service enable and requests
  input  wire logic        svc_en,
  input  wire logic [63:0] req_hi,
  input  wire logic [63:0] req_lo,
  // Consumed channels, one-cycle pulses
  output logic      [63:0] serviced
);
  logic [63:0] served_d;

  // Request drops two cycles after service; skip both cycles
  always_ff @(posedge clk) begin
    if (srst || !svc_en) begin
      serviced <= 64'h0;
      served_d <= 64'h0;
    end else begin
      serviced <= (req_hi | req_lo) & ~serviced & ~served_d;
      served_d <= serviced;
    end
  end
endmodule : erdis_partner
`default_nettype wire

// file: sim/erdis_top_bench.sv
// Self-checking bench for the event router
`timescale 1ns/1ps
`default_nettype none
`include "erdis_defs.svh"
module erdis_top_bench
  import erdis_pkg::*;
;
  // ==========================================================
  // Signals and expected reset codes
  localparam logic [31:0] HI_D = {1'b0, 5'd2, 5'd1, 5'd0, 1'b0, 5'd11, 5'd10, 5'd3};
  localparam logic [31:0] LO_D = {1'b0, 5'd9, 5'd8, 5'd7, 1'b0, 5'd6, 5'd5, 5'd4};
  logic        CLK, SRST, REG_WR, REG_RD, SVC_EN, CPU_INT_ANY, IRQ;
  logic [31:0] REG_ADDR, REG_WDATA, REG_RDATA, d;
  logic [63:0] CHAIN_EVT, CHAN_SERVICED, PARAM_HI_PRIO, CHAN_REQ_HI, CHAN_REQ_LO;
  logic [15:0] CPU_INT;
  logic [3:0]  CPU_INT_TOP;
  erdis_evt_t  PERIPH_EVT;
  erdis_isrc_t CPU_SRC;
  int          errors, samples_checked;
  // Channel of each event bit, LSB first
  byte unsigned ch_map [34] = '{40, 32, 31, 30, 29, 28, 13, 15, 18, 12, 14, 17, 8, 9, 10, 11, 4, 5, 6, 7,
                                48, 49, 50, 51, 52, 53, 54, 55, 3, 20, 1, 2, 19, 0};

  erdis_top i_erdis_top (.CLK, .SRST, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA,
    .PERIPH_EVT, .CPU_SRC, .CHAIN_EVT, .CHAN_SERVICED, .PARAM_HI_PRIO, .CHAN_REQ_HI,
    .CHAN_REQ_LO, .CPU_INT, .CPU_INT_ANY, .CPU_INT_TOP, .IRQ);
  erdis_partner i_erdis_partner (.clk(CLK), .srst(SRST), .svc_en(SVC_EN), .req_hi(CHAN_REQ_HI),
    .req_lo(CHAN_REQ_LO), .serviced(CHAN_SERVICED));

  // ==========================================================
  // Clock and watchdog; full run is about six hundred cycles
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  initial begin
    #100000;
    errors++;
    final_report;
  end

  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge CLK);
    REG_WR    <= 1'b1;
    REG_ADDR  <= a;
    REG_WDATA <= v;
    @(posedge CLK);
    REG_WR <= 1'b0;
  endtask : wr
  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [31:0] a);
    @(posedge CLK);
    REG_RD   <= 1'b1;
    REG_ADDR <= a;
    @(posedge CLK);
    REG_RD <= 1'b0;
    #1 d = REG_RDATA;
  endtask : rd
  task automatic wt(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask : wt
  task automatic pulse(input erdis_evt_t e, input logic [63:0] c);
    @(posedge CLK);
    PERIPH_EVT <= e;
    CHAIN_EVT  <= c;
    @(posedge CLK);
    PERIPH_EVT <= '0;
    CHAIN_EVT  <= '0;
  endtask : pulse
  task automatic lvl(input erdis_evt_t e, input erdis_isrc_t s);
    @(posedge CLK);
    PERIPH_EVT <= e;
    CPU_SRC    <= s;
    wt(1);
  endtask : lvl
  task automatic reqs(input logic [63:0] exp);
    chk(CHAN_REQ_HI, exp & PARAM_HI_PRIO);
    chk(CHAN_REQ_LO, exp & ~PARAM_HI_PRIO);
  endtask : reqs
  // Source line behind a selector code; reserved codes raise everything
  function automatic void pick(input int c, output erdis_evt_t e, output erdis_isrc_t s);
    e = '0;
    s = '0;
    case (c) inside
      0:           e.host = 1'b1;
      1, 2:        e.timer[c - 1] = 1'b1;
      3:           e.mem_refresh[0] = 1'b1;
      [4:7]:       e.pin[c] = 1'b1;
      8:           s.dma_done = 1'b1;
      9:           s.emu_dtdma = 1'b1;
      10:          s.emu_rtdx_rx = 1'b1;
      11:          s.emu_rtdx_tx = 1'b1;
      12, 14:      s.serial_tx[(c - 12) / 2] = 1'b1;
      13, 15:      s.serial_rx[(c - 13) / 2] = 1'b1;
      16:          e.pin[0] = 1'b1;
      17:          s.serial_tx[2] = 1'b1;
      18:          s.serial_rx[2] = 1'b1;
      19:          e.timer[2] = 1'b1;
      20:          e.mem_refresh[1] = 1'b1;
      23:          s.cell_irq = 1'b1;
      30:          s.viterbi_irq = 1'b1;
      31:          s.turbo_irq = 1'b1;
      default: begin
        e = '1;
        s = '1;
      end
    endcase
  endfunction : pick

  // ==========================================================
  // Scenarios
  task automatic t_regs;
    rd(`ERDIS_ADDR_HI_SEL);
    chk(d, HI_D);
    rd(`ERDIS_ADDR_LO_SEL);
    chk(d, LO_D);
    rd(32'h009C0000);
    chk(d, 32'h0);
    wr(`ERDIS_ADDR_HI_SEL, 32'hFFFFFFFF);
    rd(`ERDIS_ADDR_HI_SEL);
    chk(d, 32'h7FFF7FFF);
    wr(`ERDIS_ADDR_HI_SEL, HI_D);
    $display("test regs done");
  endtask : t_regs
  task automatic t_ints;
    int          code [16] = '{0, 0, 0, 0, 4, 5, 6, 7, 8, 9, 3, 10, 11, 0, 1, 2};
    erdis_evt_t  e;
    erdis_isrc_t s;
    lvl('0, erdis_isrc_t'({2'h3, 13'h0}));
    chk(CPU_INT[1:0], 2'h3);
    chk({CPU_INT_ANY, CPU_INT_TOP}, 5'h10);
    for (int i = 4; i < 16; i++) begin
      pick(code[i], e, s);
      lvl(e, s);
      chk(CPU_INT[i], 1'b1);
      chk({CPU_INT_ANY, CPU_INT_TOP}, {1'b1, 4'(i)});
      lvl('0, '0);
      chk(CPU_INT[i], 1'b0);
      chk({CPU_INT_ANY, CPU_INT_TOP}, 5'h00);
    end
    for (int c = 0; c < 32; c++) begin
      wr(`ERDIS_ADDR_LO_SEL, {LO_D[31:5], c[4:0]});
      pick(c, e, s);
      lvl(e, s);
      chk(CPU_INT[4], !(c inside {21, 22, [24:29]}));
      lvl('0, '0);
    end
    wr(`ERDIS_ADDR_LO_SEL, LO_D);
    $display("test interrupts done");
  endtask : t_ints
  task automatic t_chan;
    wr(`ERDIS_ADDR_MASK_LO, 32'hFFFFFFFF);
    wr(`ERDIS_ADDR_MASK_HI, 32'hFFFFFFFF);
    SVC_EN <= 1'b1;
    wt(8);
    for (int b = 0; b < 34; b++) begin
      pulse(erdis_evt_t'(34'h1 << b), '0);
      wt(1);
      reqs(64'h1 << ch_map[b]);
      wt(5);
      reqs('0);
    end
    wr(`ERDIS_ADDR_CONFIG, 32'h0);
    pulse(erdis_evt_t'(34'h200000026), '0);
    wt(3);
    reqs('0);
    wr(`ERDIS_ADDR_CONFIG, 32'h7);
    $display("test channels done");
  endtask : t_chan
  task automatic t_mask;
    SVC_EN <= 1'b0;
    wr(`ERDIS_ADDR_MASK_LO, 32'h0);
    pulse(erdis_evt_t'(34'h1 << 30), '0);
    wt(1);
    reqs('0);
    rd(`ERDIS_ADDR_LATCH_LO);
    chk(d, 32'h2);
    wr(`ERDIS_ADDR_MASK_LO, 32'h2);
    wt(1);
    reqs(64'h2);
    wr(`ERDIS_ADDR_LATCH_LO, 32'h2);
    wt(1);
    reqs('0);
    SVC_EN <= 1'b1;
    pulse('0, 64'h1 << 63);
    wt(1);
    reqs(64'h1 << 63);
    wt(5);
    reqs('0);
    $display("test mask done");
  endtask : t_mask
  task automatic t_irq;
    SVC_EN <= 1'b0;
    wr(`ERDIS_ADDR_STATUS, 32'h7);
    wr(`ERDIS_ADDR_IMASK, 32'h1);
    pulse(erdis_evt_t'(34'h1 << 30), '0);
    wt(0);
    chk(IRQ, 1'b1);
    wr(`ERDIS_ADDR_IMASK, 32'h0);
    wt(2);
    chk(IRQ, 1'b0);
    wr(`ERDIS_ADDR_STATUS, 32'h1);
    wr(`ERDIS_ADDR_IMASK, 32'h1);
    wt(2);
    chk(IRQ, 1'b0);
    $display("test irq done");
  endtask : t_irq

  task automatic final_report;
    $display("checked %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report

  // ==========================================================
  // Main sequence
  initial begin
    SRST          = 1'b1;
    REG_WR        = 1'b0;
    REG_RD        = 1'b0;
    REG_ADDR      = 32'h0;
    REG_WDATA     = 32'h0;
    PERIPH_EVT    = '0;
    CPU_SRC       = '0;
    CHAIN_EVT     = 64'h0;
    PARAM_HI_PRIO = 64'hA5A50F0F3C3C9999;
    SVC_EN        = 1'b0;
    repeat (3) @(posedge CLK);
    SRST <= 1'b0;
    t_regs;
    t_ints;
    t_chan;
    t_mask;
    t_irq;
    final_report;
  end
endmodule : erdis_top_bench
`default_nettype wire
